// ==== logic/tmrwv_pkg.sv ====
package tmrwv_pkg;

  // Register port addresses
  localparam logic [2:0] ADDR_CTRL_A   = 3'h0;
  localparam logic [2:0] ADDR_CTRL_B   = 3'h1;
  localparam logic [2:0] ADDR_COUNT    = 3'h2;
  localparam logic [2:0] ADDR_CMP_A    = 3'h3;
  localparam logic [2:0] ADDR_CMP_B    = 3'h4;
  localparam logic [2:0] ADDR_FLAGS    = 3'h5;

  // control_reg_a fields
  localparam int unsigned CA_ACT_A_LSB = 6;
  localparam int unsigned CA_ACT_B_LSB = 4;
  localparam int unsigned CA_WS_LSB    = 0;
  // control_reg_b fields
  localparam int unsigned CB_TOPSEL    = 3;
  localparam int unsigned CB_CS_LSB    = 0;
  // Flag register fields, write one to clear
  localparam int unsigned FLG_OVF      = 0;
  localparam int unsigned FLG_MATCH_A  = 1;
  localparam int unsigned FLG_MATCH_B  = 2;

  // Reset values
  localparam logic [1:0] RST_ACT       = 2'h0;
  localparam logic [1:0] RST_WS_LO     = 2'h0;
  localparam logic       RST_TOPSEL    = 1'b0;
  localparam logic [2:0] RST_CS        = 3'h0;

  // wave_shape_select codes
  localparam logic [2:0] WS_NORMAL     = 3'h0;
  localparam logic [2:0] WS_PC_FF      = 3'h1;
  localparam logic [2:0] WS_CTC        = 3'h2;
  localparam logic [2:0] WS_FAST_FF    = 3'h3;
  localparam logic [2:0] WS_PC_A       = 3'h5;
  localparam logic [2:0] WS_FAST_A     = 3'h7;

  // output_action codes
  localparam logic [1:0] ACT_NONE      = 2'h0;
  localparam logic [1:0] ACT_TOGGLE    = 2'h1;
  localparam logic [1:0] ACT_CLEAR     = 2'h2;
  localparam logic [1:0] ACT_SET       = 2'h3;

  // Clock select codes and prescaler masks
  localparam int unsigned PRE_W        = 10;
  localparam logic [2:0] CS_STOP       = 3'h0;
  localparam logic [2:0] CS_DIV1       = 3'h1;
  localparam logic [2:0] CS_DIV8       = 3'h2;
  localparam logic [2:0] CS_DIV64      = 3'h3;
  localparam logic [2:0] CS_DIV256     = 3'h4;
  localparam logic [2:0] CS_DIV1024    = 3'h5;
  localparam logic [9:0] PM_DIV1       = 10'h000;
  localparam logic [9:0] PM_DIV8       = 10'h007;
  localparam logic [9:0] PM_DIV64      = 10'h03F;
  localparam logic [9:0] PM_DIV256     = 10'h0FF;
  localparam logic [9:0] PM_DIV1024    = 10'h3FF;

endpackage

// ==== logic/tmrwv_core.sv ====
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module tmrwv_core
  import tmrwv_pkg::*;
#(
  parameter int unsigned CNT_W = 8
)
(
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             core_en,
  input  wire logic [2:0]       reg_addr,
  input  wire logic [CNT_W-1:0] reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [CNT_W-1:0] reg_rdata,
  output logic                  wave_out_a,
  output logic                  wave_out_b,
  output logic                  overflow_flag,
  output logic                  match_flag_a,
  output logic                  match_flag_b
);

  localparam logic [CNT_W-1:0] CNT_MAX  = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};

  logic [1:0]       act_a_q;
  logic [1:0]       act_b_q;
  logic [1:0]       ws_lo_q;
  logic             top_sel_q;
  logic [2:0]       clk_sel_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             up_q;
  logic             up_d;
  logic [CNT_W-1:0] buf_a_q;
  logic [CNT_W-1:0] buf_b_q;
  logic [CNT_W-1:0] cmp_a_q;
  logic [CNT_W-1:0] cmp_b_q;
  logic [CNT_W-1:0] cmp_a_d;
  logic [CNT_W-1:0] cmp_b_d;
  logic             block_q;
  logic [PRE_W-1:0] pre_q;
  logic             ovf_q;
  logic             mfa_q;
  logic             mfb_q;
  logic             wave_a_q;
  logic             wave_b_q;
  logic             wave_a_d;
  logic             wave_b_d;
  logic [CNT_W-1:0] rdata_q;
  logic [CNT_W-1:0] rd_mux;

  wire              wr_en     = reg_wr & core_en;
  wire              rd_en     = reg_rd & core_en;
  wire              sel_ctrl_a = wr_en && (reg_addr == ADDR_CTRL_A);
  wire              sel_ctrl_b = wr_en && (reg_addr == ADDR_CTRL_B);
  wire              cnt_wr    = wr_en && (reg_addr == ADDR_COUNT);
  wire              sel_cmp_a = wr_en && (reg_addr == ADDR_CMP_A);
  wire              sel_cmp_b = wr_en && (reg_addr == ADDR_CMP_B);
  wire              sel_flags = wr_en && (reg_addr == ADDR_FLAGS);

  // Mode decode; shapes 0x4 and 0x6 fall back to free running
  wire [2:0]        wsel      = {top_sel_q, ws_lo_q};
  wire              is_ctc    = (wsel == WS_CTC);
  wire              is_fast   = (wsel == WS_FAST_FF) || (wsel == WS_FAST_A);
  wire              is_pc     = (wsel == WS_PC_FF) || (wsel == WS_PC_A);
  wire              is_pwm    = is_fast | is_pc;
  wire              top_is_a  = is_ctc || (wsel == WS_FAST_A) || (wsel == WS_PC_A);
  wire [CNT_W-1:0]  top_val   = top_is_a ? cmp_a_q : CNT_MAX;
  wire              at_top    = (cnt_q == top_val);
  wire              at_bot    = (cnt_q == CNT_ZERO);

  // Prescaler: one tick every N core clocks
  wire [PRE_W-1:0]  pre_mask  = (clk_sel_q == CS_DIV8)    ? PM_DIV8 :
                                (clk_sel_q == CS_DIV64)   ? PM_DIV64 :
                                (clk_sel_q == CS_DIV256)  ? PM_DIV256 :
                                (clk_sel_q == CS_DIV1024) ? PM_DIV1024 : PM_DIV1;
  wire              cs_run    = (clk_sel_q != CS_STOP) && (clk_sel_q <= CS_DIV1024);
  wire              tick      = core_en && cs_run && ((pre_q & pre_mask) == pre_mask);

  // A counter write blocks matches until the next tick has passed
  wire              eq_a      = (cnt_q == cmp_a_q) && !block_q;
  wire              eq_b      = (cnt_q == cmp_b_q) && !block_q;

  // Next count for each shape
  wire [CNT_W-1:0]  cnt_inc   = cnt_q + 1'b1;
  wire [CNT_W-1:0]  cnt_dec   = cnt_q - 1'b1;
  wire [CNT_W-1:0]  cnt_pc    = up_q ? (at_top ? cnt_dec : cnt_inc) : (at_bot ? cnt_inc : cnt_dec);
  wire [CNT_W-1:0]  cnt_nxt   = is_pc   ? cnt_pc :
                                is_fast ? (at_top ? CNT_ZERO : cnt_inc) :
                                is_ctc  ? ((cnt_q == cmp_a_q) ? CNT_ZERO : cnt_inc) :
                                cnt_inc;

  // CPU write has priority over counting
  assign cnt_d = cnt_wr ? reg_wdata : (tick ? cnt_nxt : cnt_q);
  assign up_d  = !tick ? up_q : (is_pc ? (up_q ? !at_top : at_bot) : 1'b1);

  wire              ovf_ev    = tick && !cnt_wr &&
                                (is_pc   ? (!up_q && at_bot) :
                                 is_fast ? at_top :
                                 (cnt_q == CNT_MAX));

  // Buffered compare values reach the comparator only at top in PWM shapes;
  // elsewhere the comparator follows the written value at once
  wire              pwm_load  = tick && at_top && !cnt_wr;
  // Gated by the enable so a mode change cannot move the comparator while frozen
  wire              cmp_follow = !is_pwm && core_en;
  assign cmp_a_d = (!is_pwm && sel_cmp_a) ? reg_wdata :
                   (cmp_follow || pwm_load) ? buf_a_q : cmp_a_q;
  assign cmp_b_d = (!is_pwm && sel_cmp_b) ? reg_wdata :
                   (cmp_follow || pwm_load) ? buf_b_q : cmp_b_q;

  // Output action for one channel at a tick
  function automatic logic wave_nxt(
    input logic [1:0]       act,
    input logic             cur,
    input logic             eq,
    input logic             chan_a,
    input logic [CNT_W-1:0] cmp
  );
    logic tog;
    begin
      tog      = chan_a && (act == ACT_TOGGLE) && top_sel_q;
      wave_nxt = cur;
      if (act == ACT_NONE)
      begin
        wave_nxt = cur;
      end
      else if (!is_pwm)
      begin
        if (eq)
        begin
          wave_nxt = (act == ACT_TOGGLE) ? !cur : act[0];
        end
      end
      else if (tog)
      begin
        if (eq)
        begin
          wave_nxt = !cur;
        end
      end
      else if (act[1] && is_fast)
      begin
        // Top-to-bottom action wins, so a compare at top gives a flat level
        if (at_top)
        begin
          wave_nxt = !act[0];
        end
        else if (eq)
        begin
          wave_nxt = act[0];
        end
      end
      else if (act[1])
      begin
        // At bottom the level is forced to what an up-count start needs
        if (!up_q && at_bot)
        begin
          wave_nxt = (cmp != CNT_ZERO) ^ act[0];
        end
        else if (eq && !(cmp == top_val))
        begin
          wave_nxt = up_q ? act[0] : !act[0];
        end
      end
    end
  endfunction

  // A process, not an assign, so the mode signals read inside the function wake it
  always_comb
  begin
    wave_a_d = wave_a_q;
    wave_b_d = wave_b_q;
    if (tick)
    begin
      wave_a_d = wave_nxt(act_a_q, wave_a_q, eq_a, 1'b1, cmp_a_q);
      wave_b_d = wave_nxt(act_b_q, wave_b_q, eq_b, 1'b0, cmp_b_q);
    end
  end

  // Flags: a set in the same cycle as a clear wins
  wire              ovf_d     = (ovf_q & !(sel_flags & reg_wdata[FLG_OVF])) | ovf_ev;
  wire              mfa_d     = (mfa_q & !(sel_flags & reg_wdata[FLG_MATCH_A])) | (tick & eq_a);
  wire              mfb_d     = (mfb_q & !(sel_flags & reg_wdata[FLG_MATCH_B])) | (tick & eq_b);
  wire              block_d   = cnt_wr ? 1'b1 : (tick ? 1'b0 : block_q);

  always_comb
  begin
    rd_mux = CNT_ZERO;
    if (reg_addr == ADDR_CTRL_A)
    begin
      rd_mux[CA_ACT_A_LSB +: 2] = act_a_q;
      rd_mux[CA_ACT_B_LSB +: 2] = act_b_q;
      rd_mux[CA_WS_LSB +: 2]    = ws_lo_q;
    end
    else if (reg_addr == ADDR_CTRL_B)
    begin
      rd_mux[CB_TOPSEL]      = top_sel_q;
      rd_mux[CB_CS_LSB +: 3] = clk_sel_q;
    end
    else if (reg_addr == ADDR_COUNT)
    begin
      rd_mux = cnt_q;
    end
    else if (reg_addr == ADDR_CMP_A)
    begin
      rd_mux = buf_a_q;
    end
    else if (reg_addr == ADDR_CMP_B)
    begin
      rd_mux = buf_b_q;
    end
    else if (reg_addr == ADDR_FLAGS)
    begin
      rd_mux[FLG_OVF]     = ovf_q;
      rd_mux[FLG_MATCH_A] = mfa_q;
      rd_mux[FLG_MATCH_B] = mfb_q;
    end
  end

  // Read data stand for one cycle only; frozen with the rest while disabled
  wire [CNT_W-1:0]  rdata_d   = !core_en ? rdata_q : (rd_en ? rd_mux : CNT_ZERO);

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      act_a_q   <= RST_ACT;
      act_b_q   <= RST_ACT;
      ws_lo_q   <= RST_WS_LO;
      top_sel_q <= RST_TOPSEL;
      clk_sel_q <= RST_CS;
    end
    else if (sel_ctrl_a)
    begin
      act_a_q <= reg_wdata[CA_ACT_A_LSB +: 2];
      act_b_q <= reg_wdata[CA_ACT_B_LSB +: 2];
      ws_lo_q <= reg_wdata[CA_WS_LSB +: 2];
    end
    else if (sel_ctrl_b)
    begin
      top_sel_q <= reg_wdata[CB_TOPSEL];
      clk_sel_q <= reg_wdata[CB_CS_LSB +: 3];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      buf_a_q <= CNT_ZERO;
      buf_b_q <= CNT_ZERO;
    end
    else
    begin
      buf_a_q <= sel_cmp_a ? reg_wdata : buf_a_q;
      buf_b_q <= sel_cmp_b ? reg_wdata : buf_b_q;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_q <= '0;
    end
    else if (core_en)
    begin
      pre_q <= pre_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q    <= CNT_ZERO;
      up_q     <= 1'b1;
      cmp_a_q  <= CNT_ZERO;
      cmp_b_q  <= CNT_ZERO;
      block_q  <= 1'b0;
      ovf_q    <= 1'b0;
      mfa_q    <= 1'b0;
      mfb_q    <= 1'b0;
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
      rdata_q  <= CNT_ZERO;
    end
    else
    begin
      cnt_q    <= cnt_d;
      up_q     <= up_d;
      cmp_a_q  <= cmp_a_d;
      cmp_b_q  <= cmp_b_d;
      block_q  <= block_d;
      ovf_q    <= ovf_d;
      mfa_q    <= mfa_d;
      mfb_q    <= mfb_d;
      wave_a_q <= wave_a_d;
      wave_b_q <= wave_b_d;
      rdata_q  <= rdata_d;
    end
  end

  assign reg_rdata     = rdata_q;
  assign wave_out_a    = wave_a_q;
  assign wave_out_b    = wave_b_q;
  assign overflow_flag = ovf_q;
  assign match_flag_a  = mfa_q;
  assign match_flag_b  = mfb_q;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_free_tick;
    tick && !cnt_wr;
  endsequence

  sequence s_block_then_tick;
    block_q && !cnt_wr ##0 tick;
  endsequence

  chk_normal_wrap: assert property (
    s_free_tick and (wsel == WS_NORMAL) && (cnt_q == CNT_MAX) |=> (cnt_q == CNT_ZERO))
    else $error("free-running count did not wrap to zero");

  chk_overflow_wrap: assert property (
    s_free_tick and !is_pwm && (cnt_q == CNT_MAX) |=> ovf_q && (cnt_q == CNT_ZERO))
    else $error("overflow flag not set as count became zero");

  chk_ctc_clear: assert property (
    s_free_tick and is_ctc && (cnt_q == cmp_a_q) |=> (cnt_q == CNT_ZERO))
    else $error("clear-on-match did not clear the count");

  chk_match_flag: assert property (
    tick && eq_a && !sel_flags |=> mfa_q)
    else $error("match flag A not set on tick after match");

  chk_write_block: assert property (
    s_block_then_tick ##0 (!mfa_q && !mfb_q && !sel_flags) |=> !mfa_q && !mfb_q)
    else $error("match not blocked after counter write");

  chk_ctc_toggle: assert property (
    tick && is_ctc && (act_a_q == ACT_TOGGLE) && eq_a |=> (wave_a_q != $past(wave_a_q)))
    else $error("output A did not toggle on match");

  chk_fast_restart: assert property (
    s_free_tick and is_fast && at_top |=> (cnt_q == CNT_ZERO) && ovf_q)
    else $error("fast PWM did not restart after top");

  chk_pc_reverse: assert property (
    s_free_tick and is_pc && up_q && at_top && (top_val != CNT_ZERO)
      |=> !up_q && (cnt_q == $past(cnt_q) - 1'b1))
    else $error("phase-correct count did not reverse at top");

  chk_pc_bottom: assert property (
    s_free_tick and is_pc && !up_q && at_bot |=> ovf_q && up_q)
    else $error("phase-correct bottom did not set overflow");

  chk_action_none: assert property (
    (act_b_q == ACT_NONE) && !sel_ctrl_a |=> $stable(wave_b_q))
    else $error("output B moved with no action selected");

endmodule

// ==== sim/timer_waveform_modes_bench.sv ====
`timescale 1ns/1ps
module timer_waveform_modes_bench;
  import tmrwv_pkg::*;

  logic       core_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       core_en = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       wave_out_a;
  logic       wave_out_b;
  logic       overflow_flag;
  logic       match_flag_a;
  logic       match_flag_b;
  logic [7:0] rv;
  int         err_total = 0;
  int         samples_checked = 0;
  int         last;
  int         dv[4] = '{8, 64, 256, 1024};
  logic [2:0] ra[6] = '{ADDR_CTRL_A, ADDR_CTRL_B, ADDR_COUNT, ADDR_CMP_A, ADDR_CMP_B, 3'h6};
  logic [7:0] rw[6] = '{8'hFF, 8'hF8, 8'h5A, 8'hA5, 8'h3C, 8'hFF};
  logic [7:0] re[6] = '{8'hF3, 8'h08, 8'h5A, 8'hA5, 8'h3C, 8'h00};

  always #50 core_clk = ~core_clk;

  tmrwv_core u_dut (
    .core_clk      (core_clk),
    .reset_n       (reset_n),
    .core_en       (core_en),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_rdata     (reg_rdata),
    .wave_out_a    (wave_out_a),
    .wave_out_b    (wave_out_b),
    .overflow_flag (overflow_flag),
    .match_flag_a  (match_flag_a),
    .match_flag_b  (match_flag_b)
  );

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
  endtask

  // One idle edge after each write keeps the strobe from being driven twice at one edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // Next output level; m is 0 non-PWM, 1 single-slope, 2 dual-slope
  function automatic logic nw(input logic [1:0] a, input logic w, h, tg, tp, bt, dn, cz, ct,
                              input int m);
    if (m == 1 && tp && a[1])
      return ~a[0];
    if (m == 2 && bt && a[1])
      return cz ^ a[0];
    if (!h)
      return w;
    if (a == ACT_TOGGLE)
      return (m == 0 || tg) ? ~w : w;
    if (m == 2 && ct)
      return w;
    if (a[1])
      return (m == 2) ? a[0] ^ dn : a[0];
    return w;
  endfunction

  // Starts the timer at /1 and reads the count every cycle against a reference model
  task automatic run(input logic [2:0] ws, input logic [1:0] aa, ab,
                     input logic [7:0] ca, cb, st, input int n);
    logic [7:0] c;
    logic [7:0] top;
    logic [7:0] v;
    logic [2:0] f;
    logic       dn, blk, ha, hb, tp, bt, ov, ma, mb, wa, wb;
    int         m;
    m = (ws[1:0] == 2'h3) ? 1 : (ws[1:0] == 2'h1) ? 2 : 0;
    top = (ws == WS_CTC || ws[2]) ? ca : 8'hFF;
    {dn, ov, ma, mb, wa, wb} = 6'h00;
    blk = 1'b1;
    c = st;
    do_reset;
    wr(ADDR_CMP_A, ca);
    wr(ADDR_CMP_B, cb);
    wr(ADDR_CTRL_A, {aa, ab, 2'h0, ws[1:0]});
    wr(ADDR_COUNT, st);
    reg_addr <= ADDR_CTRL_B;
    reg_wdata <= {4'h0, ws[2], CS_DIV1};
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ADDR_COUNT;
    reg_rd <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      #1;
      cmp8("count", c, reg_rdata);
      ha = c == ca && !blk;
      hb = c == cb && !blk;
      tp = c == top;
      bt = dn && c == 8'h00;
      ov |= (m == 0) ? c == 8'hFF : (m == 1) ? tp : bt;
      ma |= ha;
      mb |= hb;
      wa = nw(aa, wa, ha, ws[2], tp, bt, dn, ca != 8'h00, ca == top, m);
      wb = nw(ab, wb, hb, 1'b0, tp, bt, dn, cb != 8'h00, cb == top, m);
      blk = 1'b0;
      if (m == 2 && tp && !dn)
        dn = 1'b1;
      else if (bt)
        dn = 1'b0;
      c = (m == 2) ? (dn ? c - 8'h01 : c + 8'h01) : (tp ? 8'h00 : c + 8'h01);
      cmp8("overflow", {7'h00, ov}, {7'h00, overflow_flag});
      cmp8("match flags", {6'h00, mb, ma}, {6'h00, match_flag_b, match_flag_a});
      cmp8("waves", {6'h00, wb, wa}, {6'h00, wave_out_b, wave_out_a});
    end
    reg_rd <= 1'b0;
    @(posedge core_clk);
    wr(ADDR_CTRL_B, 8'h00);
    f = {mb, ma, ov};
    rd(ADDR_FLAGS, v);
    cmp8("flags kept", {5'h00, f}, v & {5'h00, f});
    wr(ADDR_FLAGS, 8'h07);
    rd(ADDR_FLAGS, v);
    cmp8("flags cleared", 8'h00, v);
  endtask

  initial
  begin
    #(20000 * 100);
    err_total++;
    end_of_test;
  end

  initial
  begin
    do_reset;
    for (int a = 0; a < 7; a++)
    begin
      rd(a[2:0], rv);
      cmp8("reset value", 8'h00, rv);
    end
    for (int k = 0; k < 6; k++)
    begin
      wr(ra[k], rw[k]);
      rd(ra[k], rv);
      cmp8("readback", re[k], rv);
    end
    for (int k = 0; k < 4; k++)
    begin
      do_reset;
      wr(ADDR_CTRL_B, {5'h00, CS_DIV8 + 3'(k)});
      reg_addr <= ADDR_COUNT;
      reg_rd <= 1'b1;
      last = -1;
      for (int i = 0; i < 3 * dv[k]; i++)
      begin
        @(posedge core_clk);
        #1;
        if (i > 0 && reg_rdata !== rv)
        begin
          if (last >= 0)
            cmp8("tick spacing", 8'h01, {7'h00, i - last == dv[k]});
          last = i;
        end
        rv = reg_rdata;
      end
      reg_rd <= 1'b0;
      @(posedge core_clk);
    end
    // Enable low for five edges: one tick before the freeze, none during it
    do_reset;
    wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
    core_en <= 1'b0;
    repeat (5) @(posedge core_clk);
    core_en <= 1'b1;
    rd(ADDR_COUNT, rv);
    cmp8("frozen count", 8'h01, rv);
    // Compare B rewritten while fast PWM runs; the old value stays in use until top
    do_reset;
    wr(ADDR_CMP_A, 8'hC0);
    wr(ADDR_CMP_B, 8'h10);
    wr(ADDR_CTRL_A, {6'h00, WS_FAST_FF[1:0]});
    wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
    wr(ADDR_CMP_B, 8'h40);
    repeat (24) @(posedge core_clk);
    rd(ADDR_FLAGS, rv);
    cmp8("buffered compare", 8'h04, rv);
    run(WS_NORMAL, ACT_NONE, ACT_NONE, 8'hFE, 8'h02, 8'hF8, 14);
    run(WS_NORMAL, ACT_TOGGLE, ACT_SET, 8'hFA, 8'hFD, 8'hF8, 12);
    run(WS_CTC, ACT_TOGGLE, ACT_SET, 8'h05, 8'h03, 8'hFA, 24);
    run(WS_CTC, ACT_TOGGLE, ACT_NONE, 8'h00, 8'h00, 8'h00, 8);
    run(WS_FAST_FF, ACT_TOGGLE, ACT_CLEAR, 8'h40, 8'hFF, 8'hF0, 280);
    run(WS_FAST_A, ACT_TOGGLE, ACT_SET, 8'h09, 8'h00, 8'h00, 30);
    run(WS_PC_FF, ACT_CLEAR, ACT_SET, 8'hFF, 8'h00, 8'h00, 520);
    run(WS_PC_A, ACT_TOGGLE, ACT_CLEAR, 8'h06, 8'h03, 8'h00, 30);
    run(WS_PC_A, ACT_SET, ACT_CLEAR, 8'h08, 8'h02, 8'h05, 30);
    end_of_test;
  end
endmodule
